// ### design/tip_timer.sv
// Interval and PWM timer with its compare, mode and port registers
`timescale 1ns/1ps

// Summary of operation
// - Interval mode: period match raises interrupt and clears counter to zero.
// - Interval mode ignores duty compare; no match, no output change.
// - Output enable set in interval mode gives 50% square wave.
// - Interval between interrupts is period value plus one count clocks.
// - Counting starts within one count clock after run bit set.
// - Period match clears counter, inverts output if output enable set, pulses interrupt.
// - Stopping in interval mode returns interrupt and output to default.
// - New duty value written while PWM runs waits three count clocks, then takes effect at the next old-duty match; stopped, it takes effect at once.
// - PWM period match clears, interrupts, goes active, compares duty next.
// - PWM duty match goes inactive, compares period next, no clear.
// - PWM period is N plus one, active width M plus one clocks.
// - PWM start skips first count clock; output inactive until period match.
// - Stopping PWM clears interrupt and forces output inactive.
// - Direction bit zero drives the pin, one releases it; reset ones.
// - Run bit clear stops and zeroes counter; set starts counting.
// - Level bit gives default output level; PWM active is opposite.
// - Duty write in PWM is latched, moved in at first old-duty match after three count clocks.
module tip_timer (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [15:0] bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic      [7:0]  bus_rdata,
  output logic             match_interrupt,
  output logic             timer_output_pin,
  output logic      [7:0]  port0_out,
  output logic      [7:0]  port0_oe,
  output logic      [7:0]  port3_out,
  output logic      [7:0]  port3_oe
);

  tip_pkg::tip_state_t st_r, st_nxt;
  logic [7:0]  mode_r, mode_nxt;
  logic [7:0]  period_r, period_nxt;
  logic [7:0]  duty_eff_r, duty_eff_nxt;
  logic [7:0]  duty_latch_r, duty_latch_nxt;
  logic        pending_r, pending_nxt;
  logic [1:0]  age_r, age_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        duty_ph_r, duty_ph_nxt;
  logic        tout_r, tout_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  port0_dir_r, port0_dir_nxt;
  logic [7:0]  port3_dir_r, port3_dir_nxt;
  logic [7:0]  port0_latch_r, port0_latch_nxt;
  logic [7:0]  port3_latch_r, port3_latch_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic [tip_pkg::PRE_W-1:0] pre_r;
  logic [tip_pkg::PRE_W-1:0] pre_nxt;
  logic [tip_pkg::PRE_W-1:0] pre_mask;
  logic [3:0]  div_sh;
  logic        tick;
  logic        run_bit;
  logic        pwm_mode;
  logic        lev;
  logic        oen;
  logic [7:0]  target;
  logic        match;
  logic        pwm_running;

  assign run_bit  = mode_r[tip_pkg::MODE_RUN_BIT];
  assign pwm_mode = mode_r[tip_pkg::MODE_MD_HI:tip_pkg::MODE_MD_LO]
                    == tip_pkg::MD_PWM;
  assign lev      = mode_r[tip_pkg::MODE_LEV_BIT];
  assign oen      = mode_r[tip_pkg::MODE_OEN_BIT];
  // Interval mode never looks at the duty value
  // duty ignored here
  assign target   = (pwm_mode && duty_ph_r) ? duty_eff_r : period_r;
  assign match    = (cnt_r == target);
  assign pwm_running = (st_r == tip_pkg::TIP_RUN) && pwm_mode;

  // Prescaler: free running, tick when the selected low bits are all ones
  always_comb begin
    case (mode_r[tip_pkg::MODE_CKS_HI:tip_pkg::MODE_CKS_LO])
      3'h0:    div_sh = tip_pkg::DIV_SEL0;
      3'h1:    div_sh = tip_pkg::DIV_SEL1;
      3'h2:    div_sh = tip_pkg::DIV_SEL2;
      3'h3:    div_sh = tip_pkg::DIV_SEL3;
      3'h4:    div_sh = tip_pkg::DIV_SEL4;
      3'h5:    div_sh = tip_pkg::DIV_SEL5;
      3'h6:    div_sh = tip_pkg::DIV_SEL6;
      default: div_sh = tip_pkg::DIV_SEL7;
    endcase
    pre_mask = ~({tip_pkg::PRE_W{1'b1}} << div_sh);
    tick     = (pre_r & pre_mask) == pre_mask;
    pre_nxt  = pre_r + 1'b1;
  end

  // Counter, compare phase, output level and interrupt
  always_comb begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    duty_ph_nxt = duty_ph_r;
    tout_nxt    = tout_r;
    irq_nxt     = 1'b0;               // Interrupt is a one-cycle pulse
    case (st_r)
      tip_pkg::TIP_IDLE: begin
        cnt_nxt     = 8'h00;
        duty_ph_nxt = 1'b0;
        tout_nxt    = lev;
        if (run_bit) begin
          st_nxt = pwm_mode ? tip_pkg::TIP_SKIP : tip_pkg::TIP_RUN;
        end
      end
      tip_pkg::TIP_SKIP: begin
        if (!run_bit) begin
          st_nxt = tip_pkg::TIP_IDLE;
        end else if (tick) begin
          st_nxt = tip_pkg::TIP_RUN;
        end
      end
      tip_pkg::TIP_RUN: begin
        if (!run_bit) begin
          st_nxt      = tip_pkg::TIP_IDLE;
          cnt_nxt     = 8'h00;
          duty_ph_nxt = 1'b0;
          tout_nxt    = lev;
        end else if (tick) begin
          if (!pwm_mode) begin
            if (match) begin
              cnt_nxt = 8'h00;
              irq_nxt = 1'b1;
              if (oen) begin
                tout_nxt = ~tout_r;
              end
            end else begin
              cnt_nxt = cnt_r + 8'h01;
            end
          end else if (!duty_ph_r) begin
            if (match) begin
              cnt_nxt     = 8'h00;
              irq_nxt     = 1'b1;
              tout_nxt    = ~lev;
              duty_ph_nxt = 1'b1;
            end else begin
              cnt_nxt = cnt_r + 8'h01;
            end
          end else begin
            cnt_nxt = cnt_r + 8'h01;
            if (match) begin
              tout_nxt    = lev;
              duty_ph_nxt = 1'b0;
            end
          end
        end
      end
      default: st_nxt = tip_pkg::TIP_IDLE;
    endcase
  end

  // Software registers; duty written while PWM runs waits in a latch
  always_comb begin
    mode_nxt        = mode_r;
    period_nxt      = period_r;
    duty_eff_nxt    = duty_eff_r;
    duty_latch_nxt  = duty_latch_r;
    pending_nxt     = pending_r;
    age_nxt         = age_r;
    port0_dir_nxt   = port0_dir_r;
    port3_dir_nxt   = port3_dir_r;
    port0_latch_nxt = port0_latch_r;
    port3_latch_nxt = port3_latch_r;
    if (tick && age_r != tip_pkg::DUTY_XFER_TICKS) begin
      age_nxt = age_r + 2'h1;
    end
    // transfer at old-duty match after three ticks
    if (pwm_running && tick && duty_ph_r && match && pending_r
        && age_r == tip_pkg::DUTY_XFER_TICKS) begin
      duty_eff_nxt = duty_latch_r;
      pending_nxt  = 1'b0;
    end
    // Writes come last so a write in the transfer cycle is not lost
    if (bus_wr) begin
      if (bus_addr == tip_pkg::ADDR_MODE) begin
        mode_nxt = bus_wdata;
      end else if (bus_addr == tip_pkg::ADDR_PERIOD) begin
        period_nxt = bus_wdata;
      end else if (bus_addr == tip_pkg::ADDR_DUTY) begin
        duty_latch_nxt = bus_wdata;
        if (st_r != tip_pkg::TIP_IDLE && pwm_mode) begin
          pending_nxt = 1'b1;
          age_nxt     = 2'h0;
        end else begin
          duty_eff_nxt = bus_wdata;
          pending_nxt  = 1'b0;
        end
      end else if (bus_addr == tip_pkg::ADDR_PORT0_DIR) begin
        port0_dir_nxt = bus_wdata;
      end else if (bus_addr == tip_pkg::ADDR_PORT3_DIR) begin
        port3_dir_nxt = bus_wdata;
      end else if (bus_addr == tip_pkg::ADDR_PORT0_LATCH) begin
        port0_latch_nxt = bus_wdata;
      end else if (bus_addr == tip_pkg::ADDR_PORT3_LATCH) begin
        port3_latch_nxt = bus_wdata;
      end
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (bus_rd) begin
      if (bus_addr == tip_pkg::ADDR_MODE) begin
        rdata_nxt = mode_r;
      end else if (bus_addr == tip_pkg::ADDR_PERIOD) begin
        rdata_nxt = period_r;
      end else if (bus_addr == tip_pkg::ADDR_DUTY) begin
        rdata_nxt = duty_latch_r;
      end else if (bus_addr == tip_pkg::ADDR_COUNT) begin
        rdata_nxt = cnt_r;
      end else if (bus_addr == tip_pkg::ADDR_PORT0_DIR) begin
        rdata_nxt = port0_dir_r;
      end else if (bus_addr == tip_pkg::ADDR_PORT3_DIR) begin
        rdata_nxt = port3_dir_r;
      end else if (bus_addr == tip_pkg::ADDR_PORT0_LATCH) begin
        rdata_nxt = port0_latch_r;
      end else if (bus_addr == tip_pkg::ADDR_PORT3_LATCH) begin
        rdata_nxt = port3_latch_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  // State registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r          <= tip_pkg::TIP_IDLE;
      pre_r         <= '0;
      mode_r        <= tip_pkg::RST_MODE;
      period_r      <= tip_pkg::RST_CMP;
      duty_eff_r    <= tip_pkg::RST_CMP;
      duty_latch_r  <= tip_pkg::RST_CMP;
      pending_r     <= 1'b0;
      age_r         <= 2'h0;
      cnt_r         <= 8'h00;
      duty_ph_r     <= 1'b0;
      tout_r        <= 1'b0;
      irq_r         <= 1'b0;
      port0_dir_r   <= tip_pkg::RST_DIR;
      port3_dir_r   <= tip_pkg::RST_DIR;
      port0_latch_r <= tip_pkg::RST_LATCH;
      port3_latch_r <= tip_pkg::RST_LATCH;
      rdata_r       <= 8'h00;
      port0_out     <= 8'h00;
      port3_out     <= 8'h00;
      port0_oe      <= 8'h00;
      port3_oe      <= 8'h00;
    end else begin
      st_r          <= st_nxt;
      pre_r         <= pre_nxt;
      mode_r        <= mode_nxt;
      period_r      <= period_nxt;
      duty_eff_r    <= duty_eff_nxt;
      duty_latch_r  <= duty_latch_nxt;
      pending_r     <= pending_nxt;
      age_r         <= age_nxt;
      cnt_r         <= cnt_nxt;
      duty_ph_r     <= duty_ph_nxt;
      tout_r        <= tout_nxt;
      irq_r         <= irq_nxt;
      port0_dir_r   <= port0_dir_nxt;
      port3_dir_r   <= port3_dir_nxt;
      port0_latch_r <= port0_latch_nxt;
      port3_latch_r <= port3_latch_nxt;
      rdata_r       <= rdata_nxt;
      // zero direction drives pin; timer ORed onto pin 0
      port0_out     <= port0_latch_r | {7'h00, tout_r};
      port3_out     <= port3_latch_r | {7'h00, tout_r};
      port0_oe      <= ~port0_dir_r;
      port3_oe      <= ~port3_dir_r;
    end
  end

  assign bus_rdata        = rdata_r;
  assign match_interrupt  = irq_r;
  assign timer_output_pin = tout_r;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  int_match_a: assert property ((st_r == tip_pkg::TIP_RUN)
    && !pwm_mode && run_bit && tick && match |=> irq_r && cnt_r == 8'h00)
    else $error("interval match did not clear and interrupt");
  sq_toggle_a: assert property ((st_r == tip_pkg::TIP_RUN)
    && !pwm_mode && run_bit && tick && match && oen
    |=> tout_r != $past(tout_r))
    else $error("output did not invert on interval match");
  int_steady_a: assert property ((st_r == tip_pkg::TIP_RUN)
    && !pwm_mode && run_bit && !(tick && match)
    |=> $stable(tout_r) && !irq_r)
    else $error("interval output moved without period match");
  stop_default_a: assert property ((st_r == tip_pkg::TIP_RUN)
    && !run_bit |=> !irq_r && tout_r == lev && cnt_r == 8'h00)
    else $error("stop did not restore defaults");
  pwm_skip_a: assert property ((st_r == tip_pkg::TIP_IDLE)
    && run_bit && pwm_mode |=> st_r == tip_pkg::TIP_SKIP
    ##1 cnt_r == 8'h00 && tout_r == lev)
    else $error("PWM start did not mask first tick");
  int_start_a: assert property ((st_r == tip_pkg::TIP_IDLE)
    && run_bit && !pwm_mode |=> st_r == tip_pkg::TIP_RUN)
    else $error("interval start delayed");
  pwm_period_a: assert property (pwm_running && run_bit && tick
    && !duty_ph_r && match |=> irq_r && tout_r == ~lev && duty_ph_r
    && cnt_r == 8'h00)
    else $error("PWM period match wrong");
  pwm_duty_a: assert property (pwm_running && run_bit && tick
    && duty_ph_r && match |=> !irq_r && tout_r == lev && !duty_ph_r
    && cnt_r == $past(cnt_r) + 8'h01)
    else $error("PWM duty match wrong");
  duty_wait_a: assert property ($past(pwm_running)
    && !$past(bus_wr) && duty_eff_r != $past(duty_eff_r)
    |-> $past(age_r) == tip_pkg::DUTY_XFER_TICKS)
    else $error("duty moved in before three count clocks");
  dir_oe_a: assert property (##1 port3_oe == ~$past(port3_dir_r))
    else $error("port enable does not follow direction");

  int_irq_c:  cover property (!pwm_mode && irq_r ##[1:600] irq_r);
  pwm_irq_c:  cover property (pwm_mode && irq_r ##[1:600] tout_r == lev);
  duty_xfr_c: cover property (pending_r ##1 !pending_r && !$past(bus_wr));
  stop_c:     cover property ((st_r == tip_pkg::TIP_RUN) && !run_bit);

endmodule

// ### design/tip_pkg.sv
// Constants, register map and state codes for the interval and PWM timer
package tip_pkg;

  // Register byte addresses
  localparam logic [15:0] ADDR_PORT0_LATCH = 16'hff00;
  localparam logic [15:0] ADDR_PORT3_LATCH = 16'hff03;
  localparam logic [15:0] ADDR_PORT0_DIR   = 16'hff20;
  localparam logic [15:0] ADDR_PORT3_DIR   = 16'hff23;
  localparam logic [15:0] ADDR_MODE        = 16'hff6c;
  localparam logic [15:0] ADDR_PERIOD      = 16'hff70;
  localparam logic [15:0] ADDR_DUTY        = 16'hff71;
  localparam logic [15:0] ADDR_COUNT       = 16'hff72;

  // Values after reset
  localparam logic [7:0] RST_DIR   = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_CMP   = 8'h00;

  // Mode register field positions
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_CKS_HI  = 6;
  localparam int MODE_CKS_LO  = 4;
  localparam int MODE_MD_HI   = 3;
  localparam int MODE_MD_LO   = 2;
  localparam int MODE_LEV_BIT = 1;
  localparam int MODE_OEN_BIT = 0;

  // Operating modes
  localparam logic [1:0] MD_INTERVAL = 2'h0;
  localparam logic [1:0] MD_PWM      = 2'h2;

  // Count clock dividers as powers of two of the peripheral clock
  localparam logic [3:0] DIV_SEL0 = 4'h0;
  localparam logic [3:0] DIV_SEL1 = 4'h2;
  localparam logic [3:0] DIV_SEL2 = 4'h4;
  localparam logic [3:0] DIV_SEL3 = 4'h6;
  localparam logic [3:0] DIV_SEL4 = 4'hc;
  localparam logic [3:0] DIV_SEL5 = 4'h6;
  localparam logic [3:0] DIV_SEL6 = 4'hf;
  localparam logic [3:0] DIV_SEL7 = 4'h0;
  localparam int         PRE_W    = 15;

  // Count clocks a new duty value must wait before transfer
  localparam logic [1:0] DUTY_XFER_TICKS = 2'h3;

  typedef enum logic [2:0] {
    TIP_IDLE = 3'b001,
    TIP_SKIP = 3'b010,
    TIP_RUN  = 3'b100
  } tip_state_t;

endpackage

// ### tb/tip_tb.sv
// Self-checking bench for the interval and PWM timer
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  exp;
  } tip_row_t;

  logic        clock;
  logic        nrst;
  logic [15:0] bus_addr;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_rdata;
  logic        match_interrupt;
  logic        timer_output_pin;
  logic [7:0]  port0_out;
  logic [7:0]  port0_oe;
  logic [7:0]  port3_out;
  logic [7:0]  port3_oe;
  logic [7:0]  rd_val;
  int          failures;
  int          samples_checked;
  int          per;
  int          hi;
  int          hi2;

  // Write then read back; counter is read only, unmapped reads give zero
  tip_row_t rows [8] = '{
    '{16'hff20, 8'h5a, 8'h5a},
    '{16'hff23, 8'ha5, 8'ha5},
    '{16'hff00, 8'h00, 8'h00},
    '{16'hff03, 8'h3c, 8'h3c},
    '{16'hff70, 8'h03, 8'h03},
    '{16'hff71, 8'h02, 8'h02},
    '{16'hff72, 8'h55, 8'h00},
    '{16'hff10, 8'h77, 8'h00}
  };

  tip_timer dut (
    .clock            (clock),
    .nrst             (nrst),
    .bus_addr         (bus_addr),
    .bus_wr           (bus_wr),
    .bus_rd           (bus_rd),
    .bus_wdata        (bus_wdata),
    .bus_rdata        (bus_rdata),
    .match_interrupt  (match_interrupt),
    .timer_output_pin (timer_output_pin),
    .port0_out        (port0_out),
    .port0_oe         (port0_oe),
    .port3_out        (port3_out),
    .port3_oe         (port3_oe)
  );

  // 100 MHz clock
  always #5 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Strobes are raised for exactly one rising edge, launched at negedge
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge clock);
    bus_wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(negedge clock);
    bus_addr = a;
    bus_rd   = 1'b1;
    @(negedge clock);
    bus_rd = 1'b0;
    d      = bus_rdata;
  endtask

  // One period from a match pulse to the next; counts cycles at level act
  task automatic measure(input logic act, output int p, output int h);
    int n;
    n = 0;
    while (match_interrupt !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    p = 1;
    h = (timer_output_pin === act) ? 1 : 0;
    @(negedge clock);
    while (match_interrupt !== 1'b1 && n < 2000) begin
      p++;
      if (timer_output_pin === act) begin
        h++;
      end
      @(negedge clock);
      n++;
    end
  endtask

  // Watchdog well above the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    $display("unexpected at %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    clock     = 1'b0;
    nrst      = 1'b0;
    bus_addr  = 16'h0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_wdata = 8'h00;
    failures        = 0;
    samples_checked = 0;
    repeat (20) @(negedge clock);
    check(16'(port0_oe), 16'h0000, "oe in reset");
    nrst = 1'b1;
    rd_reg(16'hff20, rd_val);
    check(16'(rd_val), 16'h00ff, "port0 dir reset");
    rd_reg(16'hff23, rd_val);
    check(16'(rd_val), 16'h00ff, "port3 dir reset");
    rd_reg(16'hff6c, rd_val);
    check(16'(rd_val), 16'h0000, "mode reset");
    check(16'(port3_oe), 16'h0000, "port3 oe reset");
    $display("test reset done");

    // Register rows
    foreach (rows[i]) begin
      wr_reg(rows[i].addr, rows[i].wdata);
      rd_reg(rows[i].addr, rd_val);
      check(16'(rd_val), 16'(rows[i].exp), "register row");
    end
    check(16'(port0_oe), 16'h00a5, "port0 drive enable");
    check(16'(port3_oe), 16'h005a, "port3 drive enable");
    $display("test registers done");

    // Interval mode, period 3, output on, three clock selects
    // route port0 pin
    wr_reg(16'hff20, 8'hfe);
    for (int s = 0; s < 3; s++) begin
      wr_reg(16'hff6c, 8'h81 | 8'(s << 4));
      measure(1'b1, per, hi);
      measure(1'b1, per, hi);
      check(16'(per), 16'(4 << (2 * s)), "interval period");
      measure(1'b1, per, hi2);
      check(16'(hi + hi2), 16'(per), "square wave duty");
      // Duty register must not disturb the interval output
      wr_reg(16'hff71, 8'h00);
      measure(1'b1, per, hi);
      measure(1'b1, per, hi2);
      check(16'(hi + hi2), 16'(per), "duty ignored");
      check(16'(per), 16'(4 << (2 * s)), "period kept");
      @(negedge clock);
      @(negedge clock);
      check(16'(port0_out[0]), 16'(timer_output_pin), "pin routed");
      // Port 3 shows its latch with the timer output on bit 0
      check(16'(port3_out), 16'(8'h3c | 8'(timer_output_pin)),
            "port3 pins");
      wr_reg(16'hff6c, 8'h01 | 8'(s << 4));
      @(negedge clock);
      @(negedge clock);
      check(16'(timer_output_pin), 16'h0000, "stop pin");
      check(16'(match_interrupt), 16'h0000, "stop irq");
      rd_reg(16'hff72, rd_val);
      check(16'(rd_val), 16'h0000, "stop counter");
    end
    $display("test interval done");

    // PWM, period 5, duty 2, low default level
    // period set first
    wr_reg(16'hff70, 8'h05);
    wr_reg(16'hff71, 8'h02);
    wr_reg(16'hff6c, 8'h89);
    @(negedge clock);
    check(16'(timer_output_pin), 16'h0000, "pwm start level");
    measure(1'b1, per, hi);
    check(16'(per), 16'h0006, "pwm period");
    check(16'(hi), 16'h0003, "pwm active width");
    // Duty changed in flight, effective after the latch transfer
    wr_reg(16'hff71, 8'h04);
    measure(1'b1, per, hi);
    // Write came one tick before the old match, so the old width stays
    check(16'(hi), 16'h0003, "old duty kept");
    measure(1'b1, per, hi);
    measure(1'b1, per, hi);
    check(16'(hi), 16'h0005, "new duty width");
    check(16'(per), 16'h0006, "period after duty");
    wr_reg(16'hff6c, 8'h09);
    @(negedge clock);
    @(negedge clock);
    check(16'(timer_output_pin), 16'h0000, "pwm stop pin");
    check(16'(match_interrupt), 16'h0000, "pwm stop irq");
    $display("test pwm low done");

    // PWM with high default level, so active is low
    // duty rewritten at restart
    wr_reg(16'hff71, 8'h01);
    wr_reg(16'hff6c, 8'h8b);
    @(negedge clock);
    @(negedge clock);
    check(16'(timer_output_pin), 16'h0001, "inactive high");
    measure(1'b0, per, hi);
    measure(1'b0, per, hi);
    check(16'(per), 16'h0006, "pwm high period");
    check(16'(hi), 16'h0002, "active low width");
    wr_reg(16'hff6c, 8'h0b);
    @(negedge clock);
    @(negedge clock);
    check(16'(timer_output_pin), 16'h0001, "stop high level");
    $display("test pwm high done");

    // Output enable clear: pin rests at the high default, no toggling
    wr_reg(16'hff6c, 8'h82);
    measure(1'b1, per, hi);
    measure(1'b1, per, hi);
    check(16'(hi), 16'(per), "no toggle when disabled");
    check(16'(per), 16'h0006, "interval period six");
    // Reset while running; pins and directions return to reset state
    nrst = 1'b0;
    @(negedge clock);
    check(16'(timer_output_pin), 16'h0000, "pin held in reset");
    check(16'(port0_oe), 16'h0000, "oe held in reset");
    check(16'(port3_out), 16'h0000, "port3 held in reset");
    check(16'(match_interrupt), 16'h0000, "irq held in reset");
    nrst = 1'b1;
    rd_reg(16'hff20, rd_val);
    check(16'(rd_val), 16'h00ff, "dir after reset");
    rd_reg(16'hff6c, rd_val);
    check(16'(rd_val), 16'h0000, "mode after reset");
    $display("test reset in run done");
    complete_run();
  end
endmodule
